//--- rtl/arw_pkg.sv
package arw_pkg;
	// ****************************************
	// field codes
	// ****************************************
	localparam logic [1:0] REF_INTERNAL = 2'h0;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	localparam logic [1:0] REF_EXTERNAL = 2'h2;
	localparam logic [2:0] WIN_OFF = 3'h0;
	localparam logic [2:0] WIN_BELOW = 3'h1;
	localparam logic [2:0] WIN_ABOVE = 3'h2;
	localparam logic [2:0] WIN_INSIDE = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;
	localparam logic [2:0] ACC_MAX = 3'h6;
	localparam logic [4:0] CH_TEMP = 5'h1e;
	localparam logic [3:0] CONV_CYCLES = 4'hd;
	localparam logic [15:0] RESULT_MAX = 16'h03ff;
	localparam int CONV_W = 10;
	localparam int RES_W = 16;
	typedef enum logic [1:0] {
		ARW_IDLE = 2'b00,
		ARW_DELAY = 2'b01,
		ARW_SAMPLE = 2'b10,
		ARW_CONVERT = 2'b11
	} arw_state_t;
endpackage

//--- rtl/arw_win_if.sv
// comparator operands and verdict travel together
interface arw_win_if;
	logic [15:0] value;
	logic [15:0] low;
	logic [15:0] high;
	logic [2:0] mode;
	logic hit;
	modport ctrl (output value, output low, output high, output mode, input hit);
	modport cmp (input value, input low, input high, input mode, output hit);
endinterface

//--- rtl/arw_window_cmp.sv
module arw_window_cmp (
	arw_win_if.cmp win // compare operands and verdict
);
	wire below = win.value < win.low;
	wire above = win.value > win.high;
	wire in_window = (win.value > win.low) && (win.value < win.high);
	// ****************************************
	// condition select, zero mode never hits
	// ****************************************
	assign win.hit = (win.mode == arw_pkg::WIN_BELOW) ? below :
		(win.mode == arw_pkg::WIN_ABOVE) ? above :
		(win.mode == arw_pkg::WIN_INSIDE) ? in_window :
		(win.mode == arw_pkg::WIN_OUTSIDE) ? (below || above) :
		1'b0;
endmodule

//--- rtl/arw_ctrl.sv
module arw_ctrl (
	input wire logic clk_i, // peripheral clock
	input wire logic rst_i, // async reset, active high
	input wire logic enable_i, // converter enable
	input wire logic free_run_i, // free-running mode
	input wire logic run_in_standby_i, // keep running in standby
	input wire logic standby_i, // chip in standby sleep
	input wire logic power_down_i, // chip in power-down sleep
	input wire logic touch_controller_i, // touch controller owns the converter
	input wire logic [1:0] reference_select_i, // reference code
	input wire logic [4:0] input_channel_select_i, // input channel
	input wire logic [2:0] accumulation_count_i, // log2 samples
	input wire logic [2:0] initial_delay_i, // first start delay cycles
	input wire logic [4:0] sample_length_i, // sample length, unused: the sample phase is always 2 cycles
	input wire logic [2:0] window_compare_mode_i, // window condition
	input wire logic [15:0] window_low_threshold_i, // low threshold
	input wire logic [15:0] window_high_threshold_i, // high threshold
	input wire logic event_start_enable_i, // allow event starts
	input wire logic start_event_i, // event fabric trigger
	input wire logic start_write_i, // software writes 1 to start bit
	input wire logic result_read_i, // software reads result
	input wire logic result_ready_clear_i, // software writes 1 to flag
	input wire logic window_flag_clear_i, // software writes 1 to flag
	input wire logic result_ready_ie_i, // result ready interrupt enable
	input wire logic window_ie_i, // window interrupt enable
	input wire logic [9:0] analog_sample_i, // quantised analog sample
	output logic [15:0] conversion_value_o, // accumulated result
	output logic start_conversion_o, // start bit state
	output logic result_ready_o, // result ready flag
	output logic window_compare_flag_o, // window flag
	output logic result_ready_irq_o, // result ready request
	output logic window_irq_o, // window request
	output logic result_event_o, // one-clock result event
	output logic [1:0] ref_route_o, // one-hot-free reference mux code
	output logic temp_sensor_en_o, // temperature sensor power
	output logic clock_request_o, // peripheral clock request
	output logic halted_marker_o // conversion hit by power-down
);
	arw_pkg::arw_state_t state;
	arw_pkg::arw_state_t next_state;
	logic event_q;
	logic first_done;
	logic [3:0] cnt;
	logic [6:0] samples;
	logic [15:0] acc;
	arw_win_if win ();

	arw_window_cmp i_arw_window_cmp (
		.win(win)
	);

	// ****************************************
	// decode
	// ****************************************
	// touch controller ownership masks the enable and all starts, but not reference routing
	wire own = enable_i && !touch_controller_i;
	// standby without run bit counts as stopped
	wire active = own && !(standby_i && !run_in_standby_i);
	wire paused = power_down_i;
	wire ev_rise = start_event_i && !event_q && event_start_enable_i;
	// in standby software writes cannot start anything
	wire sw_start = start_write_i && !standby_i;
	wire trig = active && !paused && (ev_rise || sw_start);
	wire [2:0] acc_code = (accumulation_count_i > arw_pkg::ACC_MAX) ?
		arw_pkg::ACC_MAX : accumulation_count_i;
	wire [6:0] samp_total = 7'h01 << acc_code;
	wire last_cycle = (state == arw_pkg::ARW_CONVERT) && (cnt == 4'h0) && !paused;
	wire last_sample = last_cycle && (samples == 7'h01);
	wire [15:0] sum = acc + {6'h00, analog_sample_i};
	wire busy = (state != arw_pkg::ARW_IDLE);
	wire again = free_run_i && active && !paused;
	assign win.value = sum;
	assign win.low = window_low_threshold_i;
	assign win.high = window_high_threshold_i;
	assign win.mode = window_compare_mode_i;
	wire win_set = last_sample && win.hit;
	wire rr_set = last_sample;

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			arw_pkg::ARW_IDLE: begin
				if (trig) begin
					next_state = (!first_done && initial_delay_i != 3'h0) ?
						arw_pkg::ARW_DELAY : arw_pkg::ARW_SAMPLE;
				end
			end
			arw_pkg::ARW_DELAY: begin
				if (!paused && cnt == 4'h0) begin
					next_state = arw_pkg::ARW_SAMPLE;
				end
			end
			arw_pkg::ARW_SAMPLE: begin
				if (!paused && cnt == 4'h0) begin
					next_state = arw_pkg::ARW_CONVERT;
				end
			end
			arw_pkg::ARW_CONVERT: begin
				if (last_cycle) begin
					next_state = (samples != 7'h01 || again) ?
						arw_pkg::ARW_SAMPLE : arw_pkg::ARW_IDLE;
				end
			end
			default: next_state = arw_pkg::ARW_IDLE;
		endcase
		if (!own) begin
			next_state = arw_pkg::ARW_IDLE;
		end
	end

	// state and cycle counter; counter reloads on each phase entry
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= arw_pkg::ARW_IDLE;
			cnt <= 4'h0;
		end else begin
			state <= next_state;
			if (next_state != state || last_cycle) begin
				cnt <= (next_state == arw_pkg::ARW_DELAY) ? {1'b0, initial_delay_i} - 4'h1 :
					(next_state == arw_pkg::ARW_SAMPLE) ? 4'h1 :
					(next_state == arw_pkg::ARW_CONVERT) ? arw_pkg::CONV_CYCLES - 4'h4 :
					4'h0;
			end else if (!paused && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end

	// sample counter, accumulator and first-start tracking
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			samples <= 7'h00;
			acc <= 16'h0000;
			first_done <= 1'b0;
			event_q <= 1'b0;
		end else begin
			event_q <= start_event_i;
			if (!active) begin
				first_done <= 1'b0;
			end else if (state == arw_pkg::ARW_SAMPLE) begin
				first_done <= 1'b1;
			end
			if (state == arw_pkg::ARW_IDLE && trig) begin
				samples <= samp_total;
				acc <= 16'h0000;
			end else if (last_sample) begin
				samples <= samp_total;
				acc <= 16'h0000;
			end else if (last_cycle) begin
				samples <= samples - 7'h01;
				acc <= sum;
			end
		end
	end

	// ****************************************
	// flags and outputs
	// ****************************************
	// set wins over any clear arriving in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_ready_o <= 1'b0;
			window_compare_flag_o <= 1'b0;
			conversion_value_o <= 16'h0000;
			result_event_o <= 1'b0;
			start_conversion_o <= 1'b0;
			halted_marker_o <= 1'b0;
		end else begin
			if (rr_set) begin
				result_ready_o <= 1'b1;
			end else if (result_read_i || result_ready_clear_i) begin
				result_ready_o <= 1'b0;
			end
			if (win_set) begin
				window_compare_flag_o <= 1'b1;
			end else if (window_flag_clear_i) begin
				window_compare_flag_o <= 1'b0;
			end
			if (rr_set) begin
				conversion_value_o <= sum;
			end
			result_event_o <= rr_set && own;
			if (trig) begin
				start_conversion_o <= 1'b1;
			end else if (!own || (last_sample && !again)) begin
				start_conversion_o <= 1'b0;
			end
			if (busy && paused) begin
				halted_marker_o <= 1'b1;
			end else if (state == arw_pkg::ARW_IDLE && trig) begin
				halted_marker_o <= 1'b0;
			end
		end
	end

	// requests, routing and clock demand registered from their causes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_ready_irq_o <= 1'b0;
			window_irq_o <= 1'b0;
			ref_route_o <= arw_pkg::REF_INTERNAL;
			temp_sensor_en_o <= 1'b0;
			clock_request_o <= 1'b0;
		end else begin
			result_ready_irq_o <= result_ready_ie_i && result_ready_o;
			window_irq_o <= window_ie_i && window_compare_flag_o;
			if (!busy) begin
				ref_route_o <= (reference_select_i == arw_pkg::REF_SUPPLY) ? arw_pkg::REF_SUPPLY :
					(reference_select_i == arw_pkg::REF_EXTERNAL) ? arw_pkg::REF_EXTERNAL :
					arw_pkg::REF_INTERNAL;
				temp_sensor_en_o <= own && (input_channel_select_i == arw_pkg::CH_TEMP);
			end
			clock_request_o <= busy || trig;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	event_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		result_event_o |=> !result_event_o)
		else $error("result event longer than one clock");
	event_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(last_sample && own) |=> (result_event_o && result_ready_o))
		else $error("result completion without event and flag");
	window_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(window_compare_mode_i == arw_pkg::WIN_OFF && !window_compare_flag_o
		&& $stable(window_compare_mode_i)) |=> !window_compare_flag_o)
		else $error("window flag raised while comparator off");
	window_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(last_cycle && samples != 7'h01)
		|=> ($stable(window_compare_flag_o) || !window_compare_flag_o))
		else $error("window flag raised before last sample");
	event_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == arw_pkg::ARW_IDLE && !event_start_enable_i && !start_write_i)
		|=> state == arw_pkg::ARW_IDLE)
		else $error("conversion started without an enabled trigger");
	irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(result_ready_ie_i && result_ready_o) [*2] |-> result_ready_irq_o)
		else $error("result request missing while flag and enable set");
	clear_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(result_read_i && !rr_set) |=> !result_ready_o)
		else $error("result flag survived a read");
	pause_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_down_i && busy && own) |=> ($stable(cnt) && !result_event_o))
		else $error("conversion advanced during power-down");
	busy_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(busy && own && $past(own)) |-> start_conversion_o)
		else $error("start bit low during conversion");
	touch_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
		touch_controller_i |=> state == arw_pkg::ARW_IDLE)
		else $error("converter ran under touch controller");
endmodule

//--- bench/arw_host_model.sv
// ****************************************
// event fabric and analog source model
// ****************************************
module arw_host_model (
	input wire logic clk_i, // peripheral clock
	input wire logic fire_i, // bench asks for one event
	input wire logic [9:0] level_i, // analog level to present
	output logic start_event_o, // one-clock event pulse
	output logic [9:0] analog_sample_o // quantised analog sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic fire_q = 1'b0;
	logic fire_d = 1'b0;
	logic [9:0] level_q = 10'h000;
	// requests are taken at the rising edge, where the bench holds them steady
	always @(posedge clk_i) begin
		fire_q <= fire_i;
		fire_d <= fire_q;
		level_q <= level_i;
	end
	// the fabric changes its pulse only at the falling edge, one cycle per request
	always @(negedge clk_i) begin
		start_event_o <= fire_q & ~fire_d;
		analog_sample_o <= level_q;
	end
	initial start_event_o = 1'b0;
	initial analog_sample_o = 10'h000;
endmodule

//--- bench/test_adc_result_window_sleep_ctrl.sv
module test_adc_result_window_sleep_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, en = 0, fr = 0, rs = 0, sb = 0, pd = 0, tc = 0, ese = 0;
	logic sw = 0, rr = 0, rc = 0, wc = 0, rie = 0, wie = 0, fire = 0;
	logic [1:0] rsel = 2'h0;
	logic [4:0] ch = 5'h00, sl = 5'h00;
	logic [2:0] acc = 3'h0, idl = 3'h3, wm = 3'h0;
	logic [15:0] lo = 16'h0000, hi = 16'h0000, val;
	logic [9:0] lvl = 10'h000, smp;
	logic sev;
	logic [15:0] cv;
	logic st, rdy, wf, rirq, wirq, ev, tse, creq, halt;
	logic [1:0] rte;
	int mismatches = 0, num_checks = 0, n, seed = 32'hb508;
	always #5 clk_i = ~clk_i;
	arw_host_model i_arw_host_model (.clk_i(clk_i), .fire_i(fire), .level_i(lvl),
		.start_event_o(sev), .analog_sample_o(smp));
	arw_ctrl i_arw_ctrl (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .free_run_i(fr),
		.run_in_standby_i(rs), .standby_i(sb), .power_down_i(pd), .touch_controller_i(tc),
		.reference_select_i(rsel), .input_channel_select_i(ch), .accumulation_count_i(acc),
		.initial_delay_i(idl), .sample_length_i(sl), .window_compare_mode_i(wm),
		.window_low_threshold_i(lo), .window_high_threshold_i(hi), .event_start_enable_i(ese),
		.start_event_i(sev), .start_write_i(sw), .result_read_i(rr), .result_ready_clear_i(rc),
		.window_flag_clear_i(wc), .result_ready_ie_i(rie), .window_ie_i(wie),
		.analog_sample_i(smp), .conversion_value_o(cv), .start_conversion_o(st),
		.result_ready_o(rdy), .window_compare_flag_o(wf), .result_ready_irq_o(rirq),
		.window_irq_o(wirq), .result_event_o(ev), .ref_route_o(rte), .temp_sensor_en_o(tse),
		.clock_request_o(creq), .halted_marker_o(halt));
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// strict comparisons, so a value equal to a threshold never hits
	function automatic logic win_exp(input logic [2:0] m, input logic [15:0] v);
		case (m)
			3'h1: return v < lo;
			3'h2: return v > hi;
			3'h3: return v > lo && v < hi;
			3'h4: return v < lo || v > hi;
			default: return 1'b0;
		endcase
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	// one trigger, by software write or by a fabric event
	task automatic trig(input logic by_event);
		if (by_event) fire = 1;
		else sw = 1;
		cyc(1);
		fire = 0;
		sw = 0;
	endtask
	// bounded wait; n holds the falling edges counted
	task automatic wait_rdy(input int lim);
		n = 1;
		while (rdy !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic clear_flags();
		rc = 1;
		wc = 1;
		cyc(1);
		rc = 0;
		wc = 0;
		cyc(1);
	endtask
	// full conversion with result, event, window and request checks
	task automatic conv(input logic by_event);
		val = 16'(lvl) << ((acc == 3'h7) ? 3'h6 : acc);
		trig(by_event);
		wait_rdy(1000);
		check("result_ready", rdy, 1);
		check("event", ev, 1);
		check("value", cv, val);
		cyc(1);
		check("event_len", ev, 0);
		check("start_clear", st, 0);
		check("window", wf, win_exp(wm, val));
		check("rdy_irq", rirq, rie);
		check("win_irq", wirq, wie & win_exp(wm, val));
		rr = 1;
		cyc(1);
		rr = 0;
		cyc(1);
		check("read_clear", rdy, 0);
		clear_flags();
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		@(negedge clk_i) rst_i = 0;
		en = 1;
		ese = 1;
		// external code assumes software set the generator level above the pin
		for (int i = 0; i < 4; i++) begin
			rsel = 2'(i);
			cyc(3);
			check("ref_route", rte, (i == 3) ? 2'h0 : 2'(i));
		end
		rsel = 2'h0;
		ch = 5'h1e; // temperature reading set-up
		sl = 5'h1f;
		cyc(3);
		check("temp_en", tse, 1);
		conv(0);
		ch = 5'h03;
		cyc(3);
		check("temp_off", tse, 0);
		// random thresholds, modes and counts with equal-threshold corners
		for (int k = 0; k < 40; k++) begin
			lvl = 10'($random(seed));
			acc = (k == 5) ? 3'h7 : 3'($unsigned($random(seed)) % 7);
			wm = 3'(k % 5);
			lo = (k % 7 == 1) ? 16'(lvl) << acc : 16'($random(seed)) & 16'h1fff;
			hi = (k % 7 == 2) ? 16'(lvl) << acc : lo + (16'($random(seed)) & 16'h1fff);
			rie = 1'($random(seed));
			wie = 1'($random(seed));
			conv(k % 2);
		end
		acc = 3'h0;
		trig(0);
		wait_rdy(1000);
		// flag is first seen at the falling edge a full conversion after the trigger
		check("latency", n, 16'(arw_pkg::CONV_CYCLES));
		clear_flags();
		ese = 0;
		trig(1);
		cyc(60);
		check("event_off", rdy, 0);
		ese = 1;
		tc = 1;
		trig(0);
		cyc(60);
		check("touch_owned", rdy, 0);
		tc = 0;
		sb = 1;
		trig(1);
		cyc(60);
		check("standby_off", rdy, 0);
		rs = 1;
		trig(1);
		cyc(3);
		check("clock_req", creq, 1);
		wait_rdy(1000);
		check("standby_run", rdy, 1);
		sb = 0;
		clear_flags();
		check("clock_rel", creq, 0);
		trig(0);
		cyc(4);
		pd = 1;
		cyc(40);
		check("halt_mark", halt, 1);
		check("frozen", rdy, 0);
		check("start_held", st, 1);
		pd = 0;
		wait_rdy(1000);
		check("resume_rdy", rdy, 1);
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		finish_test();
	end
endmodule
